// >>> twss_pkg.sv
// Constants, field layout and types of the two-wire slave / software master block
`default_nettype none
package twss_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_CONTROL = 8'hE8;
  localparam logic [7:0] ADDR_DATA = 8'h9A;
  localparam logic [7:0] ADDR_SLAVE_PRIMARY = 8'h9B;
  localparam logic [7:0] ADDR_SLAVE_SECONDARY = 8'hF2;

  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_SLAVE_PRIMARY = 8'h55;
  localparam logic [7:0] RST_SLAVE_SECONDARY = 8'h7F;
  localparam logic [7:0] RST_READ = 8'h00;

  // Control register bit positions
  localparam int BIT_MASTER_DATA_OUT = 7;
  localparam int BIT_MASTER_DATA_DRIVE = 6;
  localparam int BIT_MASTER_CLOCK_OUT = 5;
  localparam int BIT_MASTER_DATA_IN = 4;
  localparam int BIT_MASTER_SELECT = 3;
  localparam int BIT_INTERFACE_RESET = 2;
  localparam int BIT_DIRECTION = 1;
  localparam int BIT_BYTE_DONE = 0;

  // Spike filter timing on the link clock
  localparam int SPIKE_NS = 50;
  localparam int LINK_PERIOD_NS = 125;
  localparam int FILTER_CYCLES = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // Bit counting within one byte
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_COUNT_ONE = 4'h1;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Idle level of the synchronised bus lines, {clock, data}
  localparam logic [1:0] LINES_IDLE = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK_OUT = 3'b010,
    ST_HOLD = 3'b011,
    ST_TX = 3'b100,
    ST_ACK_IN = 3'b101,
    ST_RX = 3'b110
  } twss_state_type;

  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } twss_drive_type;
endpackage
`default_nettype wire

// >>> twss_core.sv
// Two-wire hardware slave with software master mode, special function register side
// Functional notes
// - Accept address matching either address register
// - Data access loads/returns byte, clears flag
// - Second data access per byte stops controller
// - Filter out line spikes below 50 ns
// - Master select bit picks software master
// - Master mode drives data from data-out bit
// - Master mode clock always driven from bit
// - Released data sampled on clock rising edge
// - Slave after reset; idle while SPI enabled
// - Start, address, direction bit set flag
// - Request needs interface and global enables
// - Request the shared vector per byte
// - First byte shows address and direction
// - Direction bit follows master read/write bit
// - Hold clock low until flag cleared
// - Flag only for bytes followed by ACK
// - Stop returns slave to idle
// - NACK returns slave to idle
// - Interface reset bit forces idle state
// - Two-wire and SPI share one request
`timescale 1ns/100ps
`default_nettype none
module twss_core #(
  parameter int SPIKE_FILTER_CYCLES = twss_pkg::FILTER_CYCLES
) (
  input wire logic clock_i, // Core clock, 25 MHz
  input wire logic reset_i, // Asynchronous reset, active high
  input wire logic link_clock_i, // Pin sampling clock
  input wire logic scl_i, // Serial clock pin level
  input wire logic sda_i, // Serial data pin level
  output var twss_pkg::twss_drive_type pin_drive_o, // Pin outputs and enables
  input wire logic [7:0] sfr_addr_i, // Register address
  input wire logic sfr_wr_i, // Register write strobe
  input wire logic sfr_rd_i, // Register read strobe
  input wire logic [7:0] sfr_wdata_i, // Register write data
  output logic [7:0] sfr_rdata_o, // Register read data
  input wire logic spi_enable_i, // SPI enable bit from SPI control
  input wire logic spi_irq_i, // SPI interrupt request
  input wire logic twowire_irq_enable_i, // Interface enable from secondary enables
  input wire logic global_irq_enable_i, // Global interrupt enable
  output logic irq_o // Shared serial interrupt request
);
  import twss_pkg::*;

  if (SPIKE_FILTER_CYCLES < 1 || SPIKE_FILTER_CYCLES > 15) begin : g_bad_filter
    $error("Spike filter length must be 1 to 15");
  end

  // Link domain: synchronise and filter both lines
  logic [1:0] link_meta;
  logic [1:0] link_sync;
  logic [1:0] link_filt;

  always_ff @(posedge link_clock_i or posedge reset_i) begin
    if (reset_i) begin
      link_meta <= LINES_IDLE;
      link_sync <= LINES_IDLE;
    end else begin
      link_meta <= {scl_i, sda_i};
      link_sync <= link_meta;
    end
  end

  // A change must persist one sample beyond the filter length to pass
  for (genvar g = 0; g < 2; g++) begin : g_filter
    logic [3:0] stable_cnt;
    always_ff @(posedge link_clock_i or posedge reset_i) begin
      if (reset_i) begin
        stable_cnt <= BIT_COUNT_ZERO;
        link_filt[g] <= 1'h1;
      end else if (link_sync[g] == link_filt[g]) begin
        stable_cnt <= BIT_COUNT_ZERO;
      end else if (stable_cnt == 4'(SPIKE_FILTER_CYCLES)) begin
        stable_cnt <= BIT_COUNT_ZERO;
        link_filt[g] <= link_sync[g];
      end else begin
        stable_cnt <= stable_cnt + BIT_COUNT_ONE;
      end
    end
  end

  // Core domain: filtered levels cross as two slow levels
  logic [1:0] core_meta;
  logic [1:0] core_sync;
  logic [1:0] core_prev;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      core_meta <= LINES_IDLE;
      core_sync <= LINES_IDLE;
      core_prev <= LINES_IDLE;
    end else begin
      core_meta <= link_filt;
      core_sync <= core_meta;
      core_prev <= core_sync;
    end
  end

  wire scl_s = core_sync[1];
  wire sda_s = core_sync[0];
  wire scl_rise = scl_s & ~core_prev[1];
  wire scl_fall = ~scl_s & core_prev[1];
  wire start_det = scl_s & core_prev[1] & ~sda_s & core_prev[0];
  wire stop_det = scl_s & core_prev[1] & sda_s & ~core_prev[0];

  // Register state
  logic master_data_out_bit;
  logic master_data_drive_enable;
  logic master_clock_out_bit;
  logic master_data_in_bit;
  logic master_select_bit;
  logic interface_reset_bit;
  logic direction_status_bit;
  logic byte_done_flag;
  logic [7:0] twowire_data;
  logic [7:0] slave_address_primary;
  logic [7:0] slave_address_secondary;
  logic accessed;
  logic stopped;

  wire sel_control = sfr_addr_i == ADDR_CONTROL;
  wire sel_data = sfr_addr_i == ADDR_DATA;
  wire sel_primary = sfr_addr_i == ADDR_SLAVE_PRIMARY;
  wire sel_secondary = sfr_addr_i == ADDR_SLAVE_SECONDARY;
  wire data_access = (sfr_wr_i | sfr_rd_i) & sel_data;
  wire active = ~spi_enable_i;
  wire master_mode = active & master_select_bit;
  wire slave_run = active & ~master_select_bit & ~interface_reset_bit & ~stopped;

  wire [7:0] control_read = {master_data_out_bit, master_data_drive_enable, master_clock_out_bit,
    master_data_in_bit, master_select_bit, interface_reset_bit, direction_status_bit, byte_done_flag};
  wire [7:0] next_rdata = sel_control ? control_read :
                          sel_data ? twowire_data :
                          sel_primary ? slave_address_primary :
                          sel_secondary ? slave_address_secondary : RST_READ;

  // Slave engine
  twss_state_type state;
  twss_state_type next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic sda_low;
  logic next_sda_low;
  logic scl_hold;
  logic next_scl_hold;
  logic acked;
  logic next_acked;
  logic next_dir;
  logic flag_set;
  logic rx_load;

  wire [6:0] rx_address = shift[7:1];
  wire addr_match = (rx_address == slave_address_primary[6:0]) |
                    (rx_address == slave_address_secondary[6:0]);

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_sda_low = sda_low;
    next_scl_hold = scl_hold;
    next_acked = acked;
    next_dir = direction_status_bit;
    flag_set = 1'h0;
    rx_load = 1'h0;
    if (!slave_run) begin
      next_state = ST_IDLE;
      next_sda_low = 1'h0;
      next_scl_hold = 1'h0;
    end else if (stop_det) begin
      next_state = ST_IDLE;
      next_sda_low = 1'h0;
      next_scl_hold = 1'h0;
    end else if (start_det) begin
      next_state = ST_ADDR;
      next_bit_cnt = BIT_COUNT_ZERO;
      next_sda_low = 1'h0;
      next_scl_hold = 1'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sda_low = 1'h0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + BIT_COUNT_ONE;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            if (addr_match) begin
              next_state = ST_ACK_OUT;
              next_sda_low = 1'h1;
              next_dir = shift[0];
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK_OUT: begin
          if (scl_fall) begin
            next_sda_low = 1'h0;
            next_scl_hold = 1'h1;
            flag_set = 1'h1;
            rx_load = 1'h1;
            next_state = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!byte_done_flag) begin
            next_scl_hold = 1'h0;
            next_bit_cnt = BIT_COUNT_ZERO;
            if (direction_status_bit) begin
              next_shift = twowire_data;
              next_sda_low = ~twowire_data[7];
              next_state = ST_TX;
            end else begin
              next_state = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            next_bit_cnt = bit_cnt + BIT_COUNT_ONE;
            if (bit_cnt == LAST_TX_BIT) begin
              next_sda_low = 1'h0;
              next_state = ST_ACK_IN;
            end else begin
              next_shift = {shift[6:0], 1'h0};
              next_sda_low = ~shift[6];
            end
          end
        end
        ST_ACK_IN: begin
          if (scl_rise) begin
            next_acked = ~sda_s;
          end else if (scl_fall) begin
            if (acked) begin
              flag_set = 1'h1;
              next_scl_hold = 1'h1;
              next_state = ST_HOLD;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + BIT_COUNT_ONE;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            next_sda_low = 1'h1;
            next_state = ST_ACK_OUT;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      bit_cnt <= BIT_COUNT_ZERO;
      shift <= RST_DATA;
      sda_low <= 1'h0;
      scl_hold <= 1'h0;
      acked <= 1'h0;
      direction_status_bit <= RST_CONTROL[BIT_DIRECTION];
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      sda_low <= next_sda_low;
      scl_hold <= next_scl_hold;
      acked <= next_acked;
      direction_status_bit <= next_dir;
    end
  end

  // Software side bits; flag and direction are not writable
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      master_data_out_bit <= RST_CONTROL[BIT_MASTER_DATA_OUT];
      master_data_drive_enable <= RST_CONTROL[BIT_MASTER_DATA_DRIVE];
      master_clock_out_bit <= RST_CONTROL[BIT_MASTER_CLOCK_OUT];
      master_select_bit <= RST_CONTROL[BIT_MASTER_SELECT];
      interface_reset_bit <= RST_CONTROL[BIT_INTERFACE_RESET];
      slave_address_primary <= RST_SLAVE_PRIMARY;
      slave_address_secondary <= RST_SLAVE_SECONDARY;
    end else begin
      if (sfr_wr_i && sel_control) begin
        master_data_out_bit <= sfr_wdata_i[BIT_MASTER_DATA_OUT];
        master_data_drive_enable <= sfr_wdata_i[BIT_MASTER_DATA_DRIVE];
        master_clock_out_bit <= sfr_wdata_i[BIT_MASTER_CLOCK_OUT];
        master_select_bit <= sfr_wdata_i[BIT_MASTER_SELECT];
        interface_reset_bit <= sfr_wdata_i[BIT_INTERFACE_RESET];
      end
      if (sfr_wr_i && sel_primary) begin
        slave_address_primary <= sfr_wdata_i;
      end
      if (sfr_wr_i && sel_secondary) begin
        slave_address_secondary <= sfr_wdata_i;
      end
    end
  end

  // Received byte overrides a write landing in the same cycle
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      twowire_data <= RST_DATA;
    end else if (rx_load && !direction_status_bit) begin
      twowire_data <= shift;
    end else if (rx_load && state == ST_ACK_OUT && next_dir) begin
      twowire_data <= shift;
    end else if (sfr_wr_i && sel_data) begin
      twowire_data <= sfr_wdata_i;
    end
  end

  // New byte wins over a clearing access in the same cycle
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      byte_done_flag <= RST_CONTROL[BIT_BYTE_DONE];
      accessed <= 1'h0;
      stopped <= 1'h0;
    end else begin
      if (interface_reset_bit || !active) begin
        byte_done_flag <= 1'h0;
      end else if (flag_set) begin
        byte_done_flag <= 1'h1;
      end else if (data_access) begin
        byte_done_flag <= 1'h0;
      end
      if (flag_set || interface_reset_bit) begin
        accessed <= 1'h0;
      end else if (data_access) begin
        accessed <= 1'h1;
      end
      if (interface_reset_bit) begin
        stopped <= 1'h0;
      end else if (data_access && accessed && !flag_set) begin
        stopped <= 1'h1;
      end
    end
  end

  // Master data-in follows the line at each rising clock edge while master mode has the data line released
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      master_data_in_bit <= RST_CONTROL[BIT_MASTER_DATA_IN];
    end else if (master_mode && !master_data_drive_enable && scl_rise) begin
      master_data_in_bit <= sda_s;
    end
  end

  // Pin drive: push-pull in master mode, pull-down only as slave
  twss_drive_type next_drive;
  assign next_drive.scl_out = master_mode & master_clock_out_bit;
  assign next_drive.scl_oe = master_mode | (active & scl_hold);
  assign next_drive.sda_out = master_mode & master_data_out_bit;
  assign next_drive.sda_oe = master_mode ? master_data_drive_enable : (active & sda_low);

  // Shared request; the core vectors both sources through one entry
  wire next_irq = (byte_done_flag & twowire_irq_enable_i & global_irq_enable_i) | spi_irq_i;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pin_drive_o <= '0;
      irq_o <= 1'h0;
      sfr_rdata_o <= RST_READ;
    end else begin
      pin_drive_o <= next_drive;
      irq_o <= next_irq;
      if (sfr_rd_i) begin
        sfr_rdata_o <= next_rdata;
      end
    end
  end

  // Checks
  sequence s_hold_twice;
    (state == ST_HOLD) && slave_run ##1 (state == ST_HOLD) && slave_run;
  endsequence

  sequence s_second_access;
    data_access && accessed && !flag_set && !interface_reset_bit;
  endsequence

  a_master_clock_drive: assert property (@(posedge clock_i) disable iff (reset_i)
    master_mode |=> pin_drive_o.scl_oe && pin_drive_o.scl_out == $past(master_clock_out_bit))
    else $error("Master clock pin not following clock-out bit");

  a_master_data_drive: assert property (@(posedge clock_i) disable iff (reset_i)
    master_mode && master_data_drive_enable |=> pin_drive_o.sda_oe && pin_drive_o.sda_out == $past(master_data_out_bit))
    else $error("Master data pin not following data-out bit");

  a_master_data_release: assert property (@(posedge clock_i) disable iff (reset_i)
    master_mode && !master_data_drive_enable |=> !pin_drive_o.sda_oe)
    else $error("Master data pin driven while released");

  a_access_clears: assert property (@(posedge clock_i) disable iff (reset_i)
    data_access && !flag_set |=> !byte_done_flag)
    else $error("Data access did not clear byte flag");

  a_double_access_stop: assert property (@(posedge clock_i) disable iff (reset_i)
    s_second_access ##1 !interface_reset_bit[*3] |-> stopped && state == ST_IDLE)
    else $error("Second data access did not stop controller");

  a_reset_bit_idle: assert property (@(posedge clock_i) disable iff (reset_i)
    interface_reset_bit |=> state == ST_IDLE && !stopped && !byte_done_flag)
    else $error("Interface reset did not force idle");

  a_irq_gating: assert property (@(posedge clock_i) disable iff (reset_i)
    !(twowire_irq_enable_i && global_irq_enable_i) && !spi_irq_i |=> !irq_o)
    else $error("Request raised without both enables");

  a_hold_clock_low: assert property (@(posedge clock_i) disable iff (reset_i)
    s_hold_twice |-> pin_drive_o.scl_oe && !pin_drive_o.scl_out)
    else $error("Clock not held low while byte pending");

  a_nomatch_idle: assert property (@(posedge clock_i) disable iff (reset_i)
    slave_run && state == ST_ADDR && scl_fall && bit_cnt == BYTE_BITS && !addr_match && !stop_det && !start_det
    |=> state == ST_IDLE ##1 !pin_drive_o.sda_oe && !byte_done_flag)
    else $error("Unmatched address was answered");

  a_stop_idle: assert property (@(posedge clock_i) disable iff (reset_i)
    stop_det && slave_run |=> state == ST_IDLE)
    else $error("Stop did not return slave to idle");

  a_spi_releases: assert property (@(posedge clock_i) disable iff (reset_i)
    spi_enable_i ##1 spi_enable_i |=> !pin_drive_o.scl_oe && !pin_drive_o.sda_oe)
    else $error("Lines driven while SPI enabled");

  a_nack_idle: assert property (@(posedge clock_i) disable iff (reset_i)
    slave_run && state == ST_ACK_IN && scl_fall && !acked && !stop_det && !start_det |=> state == ST_IDLE)
    else $error("NACK did not return slave to idle");
endmodule
`default_nettype wire

// >>> twss_master_model.sv
// External two-wire bus master model on open-drain lines with pull-ups
`timescale 1ns/100ps
`default_nettype none
module twss_master_model (
  input wire logic scl_i, // Resolved clock wire
  input wire logic sda_i, // Resolved data wire
  output logic scl_pull_o, // Low pulls clock wire down
  output logic sda_pull_o, // Low pulls data wire down
  output logic timed_out_o // Slave stretched clock too long
);
  localparam int HALF_NS = 2000;
  initial begin
    scl_pull_o = 1'b1;
    sda_pull_o = 1'b1;
    timed_out_o = 1'b0;
  end
  // Release clock and honour stretching, bounded at 500 us
  task automatic clk_high();
    int n;
    n = 0;
    scl_pull_o = 1'b1;
    while (scl_i !== 1'b1 && n < 5000) begin
      #100;
      n++;
    end
    if (n == 5000) timed_out_o = 1'b1;
    #HALF_NS;
  endtask
  // Data moves only well after the clock fall, so it never looks like start or stop
  task automatic send_bit(input logic b);
    #500;
    sda_pull_o = b;
    #HALF_NS;
    clk_high();
    scl_pull_o = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #500;
    sda_pull_o = 1'b1;
    #HALF_NS;
    clk_high();
    b = sda_i;
    scl_pull_o = 1'b0;
  endtask
  task automatic start();
    sda_pull_o = 1'b1;
    #HALF_NS;
    clk_high();
    sda_pull_o = 1'b0;
    #HALF_NS;
    scl_pull_o = 1'b0;
  endtask
  task automatic stop();
    #500;
    sda_pull_o = 1'b0;
    #HALF_NS;
    clk_high();
    sda_pull_o = 1'b1;
    #HALF_NS;
  endtask
  task automatic write_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
    get_bit(ack);
  endtask
  task automatic read_byte(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    send_bit(nack);
  endtask
  task automatic hold_data(input logic b);
    sda_pull_o = b;
  endtask
endmodule
`default_nettype wire

// >>> tb_twss_core.sv
// Self-checking bench for the two-wire slave and software master block
`timescale 1ns/100ps
`default_nettype none
`define CHECK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("BAD %s expected %h seen %h", name, exp, got); end end
module tb_twss_core;
  import twss_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic link_clock_i = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic spi_enable = 1'b0;
  logic spi_irq = 1'b0;
  logic global_en = 1'b1;
  logic irq;
  twss_drive_type pin_drive;
  wire logic scl_pull;
  wire logic sda_pull;
  wire logic timed_out;
  wire logic scl_wire = (pin_drive.scl_oe ? pin_drive.scl_out : 1'b1) & scl_pull;
  wire logic sda_wire = (pin_drive.sda_oe ? pin_drive.sda_out : 1'b1) & sda_pull;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] rd;
  logic ack;

  twss_core twss_core_inst (.clock_i(clock_i), .reset_i(reset_i), .link_clock_i(link_clock_i),
    .scl_i(scl_wire), .sda_i(sda_wire), .pin_drive_o(pin_drive), .sfr_addr_i(sfr_addr),
    .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata),
    .spi_enable_i(spi_enable), .spi_irq_i(spi_irq), .twowire_irq_enable_i(1'b1),
    .global_irq_enable_i(global_en), .irq_o(irq));
  twss_master_model twss_master_model_inst (.scl_i(scl_wire), .sda_i(sda_wire),
    .scl_pull_o(scl_pull), .sda_pull_o(sda_pull), .timed_out_o(timed_out));

  initial forever #20 clock_i = ~clock_i;
  // Odd offset keeps the link clock unrelated in phase
  initial begin
    #17;
    forever #62.5 link_clock_i = ~link_clock_i;
  end

  task automatic give_verdict();
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clock_i);
    #1 sfr_wr = 1'b0;
    @(posedge clock_i);
    #1;
  endtask
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clock_i);
    #1 sfr_rd = 1'b0;
    @(posedge clock_i);
    #1 d = sfr_rdata;
  endtask
  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
    sfr_read(a, rd);
    `CHECK("register", exp, rd)
  endtask
  // Bounded poll of the control register for the byte flag
  task automatic wait_flag();
    int n;
    n = 0;
    rd = 8'h00;
    while (rd[BIT_BYTE_DONE] !== 1'b1 && n < 200) begin
      sfr_read(ADDR_CONTROL, rd);
      n++;
    end
    if (n == 200) failures++;
  endtask
  task automatic addr_phase(input logic [7:0] a);
    twss_master_model_inst.start();
    twss_master_model_inst.write_byte(a, ack);
  endtask
  task automatic flag_is(input logic exp);
    #3000;
    sfr_read(ADDR_CONTROL, rd);
    `CHECK("byte flag", exp, rd[BIT_BYTE_DONE])
  endtask
  task automatic ctl_pins(input logic [7:0] c, input logic [3:0] exp);
    sfr_write(ADDR_CONTROL, c);
    @(posedge clock_i);
    #1;
    `CHECK("pins", exp, pin_drive)
  endtask

  initial begin
    #3000000;
    failures++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clock_i);
    #1 reset_i = 1'b0;
    check_reg(ADDR_CONTROL, RST_CONTROL);
    check_reg(ADDR_DATA, RST_DATA);
    check_reg(ADDR_SLAVE_PRIMARY, RST_SLAVE_PRIMARY);
    check_reg(ADDR_SLAVE_SECONDARY, RST_SLAVE_SECONDARY);
    check_reg(8'h11, RST_READ);
    // Write to primary address, two acknowledged bytes
    sfr_write(ADDR_SLAVE_PRIMARY, 8'h12);
    addr_phase(8'h24);
    `CHECK("ack", 1'b0, ack)
    wait_flag();
    `CHECK("flag", 1'b1, rd[BIT_BYTE_DONE])
    `CHECK("direction", 1'b0, rd[BIT_DIRECTION])
    `CHECK("scl held", 1'b1, pin_drive.scl_oe)
    `CHECK("irq", 1'b1, irq)
    check_reg(ADDR_DATA, 8'h24);
    flag_is(1'b0);
    `CHECK("irq", 1'b0, irq)
    twss_master_model_inst.write_byte(8'hA5, ack);
    wait_flag();
    `CHECK("flag", 1'b1, rd[BIT_BYTE_DONE])
    check_reg(ADDR_DATA, 8'hA5);
    twss_master_model_inst.stop();
    // Read from secondary address, master ends with no acknowledge
    global_en = 1'b0;
    addr_phase(8'hFF);
    `CHECK("ack", 1'b0, ack)
    wait_flag();
    `CHECK("direction", 1'b1, rd[BIT_DIRECTION])
    `CHECK("irq", 1'b0, irq)
    sfr_write(ADDR_DATA, 8'h3C);
    twss_master_model_inst.read_byte(1'b1, rd);
    `CHECK("tx byte", 8'h3C, rd)
    flag_is(1'b0);
    twss_master_model_inst.stop();
    global_en = 1'b1;
    addr_phase(8'h66);
    `CHECK("ack", 1'b1, ack)
    flag_is(1'b0);
    twss_master_model_inst.stop();
    // Two data accesses in one byte stop the controller
    addr_phase(8'h24);
    wait_flag();
    sfr_read(ADDR_DATA, rd);
    sfr_read(ADDR_DATA, rd);
    twss_master_model_inst.stop();
    addr_phase(8'h24);
    `CHECK("ack", 1'b1, ack)
    twss_master_model_inst.stop();
    sfr_write(ADDR_CONTROL, 8'h04);
    sfr_write(ADDR_CONTROL, 8'h00);
    addr_phase(8'h24);
    `CHECK("ack", 1'b0, ack)
    wait_flag();
    sfr_write(ADDR_CONTROL, 8'h04);
    flag_is(1'b0);
    `CHECK("scl free", 1'b0, pin_drive.scl_oe)
    sfr_write(ADDR_CONTROL, 8'h00);
    twss_master_model_inst.stop();
    // SPI enabled silences the slave; shared request
    spi_enable = 1'b1;
    addr_phase(8'h24);
    `CHECK("ack", 1'b1, ack)
    twss_master_model_inst.stop();
    spi_enable = 1'b0;
    spi_irq = 1'b1;
    repeat (3) @(posedge clock_i);
    `CHECK("irq", 1'b1, irq)
    spi_irq = 1'b0;
    // Software master mode
    ctl_pins(8'hE8, 4'hF);
    ctl_pins(8'h48, 4'h5);
    ctl_pins(8'h08, 4'h4);
    twss_master_model_inst.hold_data(1'b0);
    sfr_write(ADDR_CONTROL, 8'h28);
    #2000;
    twss_master_model_inst.hold_data(1'b1);
    #2000;
    check_reg(ADDR_CONTROL, 8'h28);
    sfr_write(ADDR_CONTROL, 8'h08);
    // Low phase must outlast the spike filter
    #2000;
    sfr_write(ADDR_CONTROL, 8'h28);
    #2000;
    check_reg(ADDR_CONTROL, 8'h38);
    ctl_pins(8'h00, 4'h0);
    `CHECK("model", 1'b0, timed_out)
    give_verdict();
  end
endmodule
`default_nettype wire
